// File: src/dbf_consts.vh
`ifndef DBF_CONSTS_VH
`define DBF_CONSTS_VH
// Array geometry of one block
`define DBF_BLK_WORDS    32768
`define DBF_IDX_W        15
`define DBF_ROWS         1024
`define DBF_ROW_BYTES    64
`define DBF_SECT_ROWS    8
`define DBF_SECT_BYTES   512
`define DBF_SECT_W       7
`define DBF_SECT_FIRST   8'h00
`define DBF_SECT_LAST    8'hff
`define DBF_LAST_IDX     15'h7fff
`define DBF_ERASED       16'hffff
// Program pulse length in clock cycles
`define DBF_PROG_CYC     16'h0010
// Command codes
`define DBF_CMD_VERIFY   8'h05
`define DBF_CMD_PROG     8'h20
`define DBF_CMD_SECT     8'h40
`define DBF_CMD_MASS     8'h41
// Fixed pages behind the three unpaged processor windows
`define DBF_PAGE_A       6'h3d
`define DBF_PAGE_B       6'h3e
`define DBF_PAGE_D       6'h3f
`define DBF_PAGE_BLK     2
// Mapped address layout {block, relative byte address}
`define DBF_MAP_BLK      16
`define DBF_MAP_IDX      15:1
`define DBF_MAP_ODD      0
// Options word holding both protection bytes, in block 0
`define DBF_OPT_IDX      15'h7f86
// Protection byte fields
`define DBF_BLOCK_PROGRAM_OPEN_BIT 7
`define DBF_P_HDIS       5
`define DBF_P_HS         4:3
`define DBF_P_LDIS       2
`define DBF_P_LS         1:0
`define DBF_LOW_UNIT     15'h0100
`define DBF_HIGH_UNIT    15'h0400
`define DBF_PROT_RST     8'hff
// Command sequence states
`define DBF_SEQ_IDLE     2'h0
`define DBF_SEQ_DATA     2'h1
`define DBF_SEQ_CMD      2'h2
`endif

// File: src/dbf_bank.v
`timescale 1ns/1ps
`include "dbf_consts.vh"

module dbf_bank #(
  parameter [15:0] PROG_CYC = `DBF_PROG_CYC
) (
  // Clock and reset
  input  wire                  clk,
  input  wire                  resetn,
  // Command launch
  input  wire                  start,
  input  wire [7:0]            cmd,
  input  wire [`DBF_IDX_W-1:0] idx,
  input  wire [15:0]           data,
  // Read port
  input  wire [`DBF_IDX_W-1:0] rdIdx,
  output wire [15:0]           rdWord,
  // Status
  output wire                  busy,
  output reg                   done_q,
  output reg                   verOk_q
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg [15:0]           mem [0:`DBF_BLK_WORDS-1];
  reg                  st_q;
  reg [7:0]            cmd_q;
  reg [`DBF_IDX_W-1:0] ptr_q;
  reg [`DBF_IDX_W-1:0] last_q;
  reg [15:0]           dat_q;
  reg [15:0]           wait_q;
  integer              i;

  // Sector of the addressed word, from the byte address bits above bit 8
  wire [`DBF_SECT_W-1:0] sector = idx[`DBF_IDX_W-1:`DBF_IDX_W-`DBF_SECT_W];
  wire                   step   = (st_q == ST_RUN) && (wait_q == 16'h0000);

  assign rdWord = mem[rdIdx];
  assign busy   = st_q;

  // Array leaves the factory erased
  initial
  begin
    for (i = 0; i < `DBF_BLK_WORDS; i = i + 1)
      mem[i] = `DBF_ERASED;
  end

  // Program clears bits only, erase sets a whole range to ones
  always @(posedge clk)
  begin
    if (step && cmd_q == `DBF_CMD_PROG)
      mem[ptr_q] <= mem[ptr_q] & dat_q;
    else if (step && cmd_q != `DBF_CMD_VERIFY)
      mem[ptr_q] <= `DBF_ERASED;
  end

  // Engine walks one word per cycle from ptr to last
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q    <= ST_IDLE;
      cmd_q   <= 8'h00;
      ptr_q   <= 15'h0000;
      last_q  <= 15'h0000;
      dat_q   <= 16'h0000;
      wait_q  <= 16'h0000;
      done_q  <= 1'b0;
      verOk_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE:
          if (start)
          begin
            st_q  <= ST_RUN;
            cmd_q <= cmd;
            dat_q <= data;
            if (cmd == `DBF_CMD_VERIFY)
              verOk_q <= 1'b1;
            if (cmd == `DBF_CMD_PROG)
            begin
              ptr_q  <= idx;
              last_q <= idx;
              wait_q <= PROG_CYC - 16'h0001;
            end
            else if (cmd == `DBF_CMD_SECT)
            begin
              ptr_q  <= {sector, `DBF_SECT_FIRST};
              last_q <= {sector, `DBF_SECT_LAST};
              wait_q <= 16'h0000;
            end
            else
            begin
              ptr_q  <= 15'h0000;
              last_q <= `DBF_LAST_IDX;
              wait_q <= 16'h0000;
            end
          end
        ST_RUN:
          if (wait_q != 16'h0000)
            wait_q <= wait_q - 16'h0001;
          else
          begin
            if (cmd_q == `DBF_CMD_VERIFY && mem[ptr_q] != `DBF_ERASED)
              verOk_q <= 1'b0;
            if (ptr_q == last_q)
            begin
              st_q   <= ST_IDLE;
              done_q <= 1'b1;
            end
            else
              ptr_q <= ptr_q + 15'h0001;
          end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // dbf_bank

// File: src/dbf_array_access.v
`timescale 1ns/1ps
`include "dbf_consts.vh"

module dbf_array_access #(
  parameter [15:0] PROG_CYC = `DBF_PROG_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Array read
  input  wire        rdReq,
  input  wire        rdWordSel,
  input  wire [15:0] rdAddr,
  input  wire [5:0]  pageWindowSelect,
  output reg  [15:0] rdData,
  output reg         rdValid,
  output reg         rdBusy,
  // Command steps
  input  wire        registerBankChoice,
  input  wire        arrWr,
  input  wire [15:0] arrAddr,
  input  wire [15:0] arrData,
  input  wire        cmdWr,
  input  wire [7:0]  cmdCode,
  input  wire        cmdLaunch,
  input  wire        errClr,
  // Interrupt enables and requests
  input  wire        ccIntEn,
  input  wire        cbeIntEn,
  output reg         irqCmdDone,
  output reg         irqBufEmpty,
  // Options ready flag and per block status
  output reg         optReady,
  output wire [1:0]  bufEmpty,
  output wire [1:0]  cmdIdle,
  output wire [1:0]  cmdDone,
  output wire [1:0]  verifyOk,
  output wire [1:0]  accErr,
  output wire [1:0]  protViol,
  output wire [15:0] protByte
);
  reg  [7:0]  hold_q;
  reg  [15:0] nxt_q;
  wire [31:0] words;
  wire [1:0]  busyW;

  // Window decode: logical address and page to {block, relative address}
  function [16:0] mapAddr;
    input [15:0] a;
    input [5:0]  pg;
    reg   [5:0]  p;
    begin
      case (a[15:14])
        2'h0:    p = `DBF_PAGE_A;
        2'h1:    p = `DBF_PAGE_B;
        2'h2:    p = pg;
        default: p = `DBF_PAGE_D;
      endcase
      mapAddr = {~p[`DBF_PAGE_BLK], p[1:0], a[13:0]};
    end
  endfunction

  // True when protection refuses the command at this word
  function refuse;
    input [7:0]            pr;
    input [`DBF_IDX_W-1:0] ix;
    input [7:0]            c;
    reg                    lowOn;
    reg                    highOn;
    reg                    lowHit;
    reg                    highHit;
    begin
      lowOn   = ~pr[`DBF_P_LDIS];
      highOn  = ~pr[`DBF_P_HDIS];
      lowHit  = lowOn && (ix < (`DBF_LOW_UNIT << pr[`DBF_P_LS]));
      highHit = highOn && (ix > (`DBF_LAST_IDX - (`DBF_HIGH_UNIT << pr[`DBF_P_HS])));
      if (c == `DBF_CMD_VERIFY)
        refuse = 1'b0;
      else if (!pr[`DBF_BLOCK_PROGRAM_OPEN_BIT])
        refuse = 1'b1;
      else if (c == `DBF_CMD_MASS)
        refuse = lowOn || highOn;
      else
        refuse = lowHit || highHit;
    end
  endfunction

  // Read side address: second half of a misaligned word uses the next byte
  wire [15:0] curAddr = rdBusy ? nxt_q : rdAddr;
  wire [16:0] rMap    = mapAddr(curAddr, pageWindowSelect);
  wire [16:0] wMap    = mapAddr(arrAddr, pageWindowSelect);
  wire [15:0] rWord   = rMap[`DBF_MAP_BLK] ? words[31:16] : words[15:0];
  wire [7:0]  rByte   = rMap[`DBF_MAP_ODD] ? rWord[7:0] : rWord[15:8];

  // Options word loads both protection registers after reset
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      optReady <= 1'b0;
    else
      optReady <= 1'b1;
  end

  // Read path
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdData  <= 16'h0000;
      rdValid <= 1'b0;
      rdBusy  <= 1'b0;
      hold_q  <= 8'h00;
      nxt_q   <= 16'h0000;
    end
    else if (rdBusy)
    begin
      rdData  <= {hold_q, rByte};
      rdValid <= 1'b1;
      rdBusy  <= 1'b0;
    end
    else if (rdReq && optReady)
    begin
      if (rdWordSel && rdAddr[`DBF_MAP_ODD])
      begin
        hold_q  <= rByte;
        nxt_q   <= rdAddr + 16'h0001;
        rdBusy  <= 1'b1;
        rdValid <= 1'b0;
      end
      else
      begin
        rdData  <= rdWordSel ? rWord : {8'h00, rByte};
        rdValid <= 1'b1;
      end
    end
    else
      rdValid <= 1'b0;
  end

  // Interrupt requests gated by their enables
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqCmdDone  <= 1'b0;
      irqBufEmpty <= 1'b0;
    end
    else
    begin
      irqCmdDone  <= ccIntEn && (&cmdIdle);
      irqBufEmpty <= cbeIntEn && (&bufEmpty);
    end
  end

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1)
    begin : gBank
      localparam [0:0] ME = (b == 1) ? 1'b1 : 1'b0;
      reg  [1:0]            seq_q;
      reg                   emp_q;
      reg                   idle_q;
      reg                   err_q;
      reg                   viol_q;
      reg  [7:0]            cmd_q;
      reg  [`DBF_IDX_W-1:0] idx_q;
      reg  [15:0]           dat_q;
      reg  [7:0]            protectionRegister_q;
      wire                  wrMe  = arrWr && optReady && (wMap[`DBF_MAP_BLK] == ME);
      wire                  cmdMe = cmdWr && optReady && (registerBankChoice == ME);
      wire                  goMe  = cmdLaunch && optReady && (registerBankChoice == ME);
      wire                  start = ~emp_q && ~busyW[b];
      wire                  legal = (cmdCode == `DBF_CMD_VERIFY) ||
                                    (cmdCode == `DBF_CMD_PROG) ||
                                    (cmdCode == `DBF_CMD_SECT) ||
                                    (cmdCode == `DBF_CMD_MASS);
      wire [`DBF_IDX_W-1:0] rIdx  = (ME == 1'b0 && !optReady) ? `DBF_OPT_IDX : rMap[`DBF_MAP_IDX];

      assign bufEmpty[b] = emp_q;
      assign cmdIdle[b]  = idle_q;
      assign accErr[b]   = err_q;
      assign protViol[b] = viol_q;
      assign protByte[b*8 +: 8] = protectionRegister_q;

      // Command sequence, buffer stage and protection check
      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          seq_q  <= `DBF_SEQ_IDLE;
          emp_q  <= 1'b1;
          idle_q <= 1'b1;
          err_q  <= 1'b0;
          viol_q <= 1'b0;
          cmd_q  <= 8'h00;
          idx_q  <= 15'h0000;
          dat_q  <= 16'h0000;
          protectionRegister_q <= `DBF_PROT_RST;
        end
        else if (!optReady)
          protectionRegister_q <= ME ? words[15:8] : words[7:0];
        else
        begin
          idle_q <= emp_q && ~busyW[b];
          if (errClr)
          begin
            err_q  <= 1'b0;
            viol_q <= 1'b0;
          end
          if (start)
            emp_q <= 1'b1;
          case (seq_q)
            `DBF_SEQ_IDLE:
              if (wrMe && emp_q && !arrAddr[`DBF_MAP_ODD])
              begin
                idx_q <= wMap[`DBF_MAP_IDX];
                dat_q <= arrData;
                seq_q <= `DBF_SEQ_DATA;
              end
              else if (wrMe || cmdMe || goMe)
                err_q <= 1'b1;
            `DBF_SEQ_DATA:
              if (cmdMe && legal)
              begin
                cmd_q <= cmdCode;
                seq_q <= `DBF_SEQ_CMD;
              end
              else if (wrMe || cmdMe || goMe)
              begin
                err_q <= 1'b1;
                seq_q <= `DBF_SEQ_IDLE;
              end
            `DBF_SEQ_CMD:
              if (goMe && refuse(protectionRegister_q, idx_q, cmd_q))
              begin
                viol_q <= 1'b1;
                seq_q  <= `DBF_SEQ_IDLE;
              end
              else if (goMe)
              begin
                emp_q <= 1'b0;
                seq_q <= `DBF_SEQ_IDLE;
              end
              else if (wrMe || cmdMe)
              begin
                err_q <= 1'b1;
                seq_q <= `DBF_SEQ_IDLE;
              end
            default: seq_q <= `DBF_SEQ_IDLE;
          endcase
        end
      end

      // One independent array and engine per block
      dbf_bank #(
        .PROG_CYC (PROG_CYC)
      ) uBank (
        .clk     (clk),
        .resetn  (resetn),
        .start   (start),
        .cmd     (cmd_q),
        .idx     (idx_q),
        .data    (dat_q),
        .rdIdx   (rIdx),
        .rdWord  (words[b*16 +: 16]),
        .busy    (busyW[b]),
        .done_q  (cmdDone[b]),
        .verOk_q (verifyOk[b])
      );
    end
  endgenerate
endmodule // dbf_array_access

// File: tb/dbfa_monitor.sv
`timescale 1ns/1ps
module dbfa_monitor (
  // Clock and reset
  input wire        clk,
  input wire        resetn,
  // Read side
  input wire        rdReq,
  input wire        rdWordSel,
  input wire [15:0] rdAddr,
  input wire [15:0] rdData,
  input wire        rdValid,
  input wire        rdBusy,
  input wire        optReady,
  // Command side
  input wire        errClr,
  input wire        ccIntEn,
  input wire        cbeIntEn,
  input wire        irqCmdDone,
  input wire        irqBufEmpty,
  input wire [1:0]  bufEmpty,
  input wire [1:0]  cmdIdle,
  input wire [1:0]  cmdDone,
  input wire [1:0]  accErr,
  input wire [1:0]  protViol
);
  // Read taken at this edge
  wire take = rdReq && !rdBusy && optReady;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Read latency and data shape
  byte_read_a: assert property (take && !rdWordSel |=> rdValid && rdData[15:8] == 8'h00)
    else $error("byte read late or upper byte set");
  aligned_word_a: assert property (take && rdWordSel && !rdAddr[0] |=> rdValid && !rdBusy)
    else $error("aligned word not in one cycle");
  split_word_a: assert property (take && rdWordSel && rdAddr[0] |=>
    rdBusy && !rdValid ##1 rdValid && !rdBusy) else $error("misaligned word not in two cycles");
  busy_once_a: assert property (rdBusy |=> !rdBusy)
    else $error("read busy held too long");
  // Completion pulse and sticky errors
  done_pulse_a: assert property (cmdDone != 2'b00 |=> (cmdDone & $past(cmdDone)) == 2'b00)
    else $error("done pulse longer than one cycle");
  prot_sticky_a: assert property (!errClr |=> (protViol & $past(protViol)) == $past(protViol))
    else $error("protection flag dropped");
  err_sticky_a: assert property (!errClr |=> (accErr & $past(accErr)) == $past(accErr))
    else $error("sequence error dropped");
  // Interrupt levels follow status; options ready after reset
  irq_done_a: assert property (resetn |=> irqCmdDone == $past(ccIntEn && cmdIdle == 2'b11))
    else $error("completion interrupt wrong");
  irq_empty_a: assert property (resetn |=> irqBufEmpty == $past(cbeIntEn && bufEmpty == 2'b11))
    else $error("buffer empty interrupt wrong");
  opt_ready_a: assert property (resetn |=> optReady)
    else $error("options not ready after reset");
endmodule // dbfa_monitor

bind dbf_array_access dbfa_monitor mon (
  .clk(clk), .resetn(resetn), .rdReq(rdReq), .rdWordSel(rdWordSel), .rdAddr(rdAddr),
  .rdData(rdData), .rdValid(rdValid), .rdBusy(rdBusy), .optReady(optReady),
  .errClr(errClr), .ccIntEn(ccIntEn), .cbeIntEn(cbeIntEn), .irqCmdDone(irqCmdDone),
  .irqBufEmpty(irqBufEmpty), .bufEmpty(bufEmpty), .cmdIdle(cmdIdle), .cmdDone(cmdDone),
  .accErr(accErr), .protViol(protViol)
);

// File: tb/dbfa_core_model.sv
`timescale 1ns/1ps
module dbfa_core_model (
  // Clock
  input  wire         clk,
  // Read port
  output logic        rdReq,
  output logic        rdWordSel,
  output logic [15:0] rdAddr,
  output logic [5:0]  pageWindowSelect,
  input  wire  [15:0] rdData,
  input  wire         rdValid,
  input  wire         rdBusy,
  input  wire         optReady,
  // Command steps
  output logic        registerBankChoice,
  output logic        arrWr,
  output logic [15:0] arrAddr,
  output logic [15:0] arrData,
  output logic        cmdWr,
  output logic [7:0]  cmdCode,
  output logic        cmdLaunch
);
  // Idle bus at time zero
  initial
  begin
    {rdReq, rdWordSel, rdAddr, pageWindowSelect} = '0;
    {registerBankChoice, arrWr, arrAddr, arrData, cmdWr, cmdCode, cmdLaunch} = '0;
  end

  // One read, held until taken; released address shows no stale value
  task automatic do_read(input logic [15:0] a, input logic [5:0] pg, input logic w,
                         output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rdReq <= 1'b1;
    rdWordSel <= w;
    rdAddr <= a;
    pageWindowSelect <= pg;
    @(posedge clk);
    while ((rdBusy || !optReady) && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    rdReq <= 1'b0;
    rdAddr <= ~a;
    n = 0;
    @(posedge clk);
    while (!rdValid && n < 4)
    begin
      @(posedge clk);
      n++;
    end
    d = rdValid ? rdData : 16'hxxxx;
  endtask

  // Write, command and launch steps on consecutive edges
  task automatic do_cmd(input logic bank, input logic [15:0] a, input logic [5:0] pg,
                        input logic [15:0] d, input logic [7:0] code);
    @(posedge clk);
    pageWindowSelect <= pg;
    arrWr <= 1'b1;
    arrAddr <= a;
    arrData <= d;
    @(posedge clk);
    arrWr <= 1'b0;
    arrAddr <= ~a;
    arrData <= ~d;
    registerBankChoice <= bank;
    cmdWr <= 1'b1;
    cmdCode <= code;
    @(posedge clk);
    cmdWr <= 1'b0;
    cmdCode <= ~code;
    cmdLaunch <= 1'b1;
    @(posedge clk);
    cmdLaunch <= 1'b0;
  endtask

  // Launch with no preceding steps
  task automatic launch_only(input logic bank);
    @(posedge clk);
    registerBankChoice <= bank;
    cmdLaunch <= 1'b1;
    @(posedge clk);
    cmdLaunch <= 1'b0;
  endtask
endmodule // dbfa_core_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        errClr = 1'b0;
  logic        ccIntEn = 1'b0;
  logic        cbeIntEn = 1'b0;
  wire         rdReq, rdWordSel, rdValid, rdBusy, optReady, bankSel, arrWr, cmdWr, cmdLaunch;
  wire         irqCmdDone, irqBufEmpty;
  wire  [15:0] rdAddr, rdData, arrAddr, arrData, protByte;
  wire  [7:0]  cmdCode;
  wire  [5:0]  pageSel;
  wire  [1:0]  bufEmpty, cmdIdle, cmdDone, verifyOk, accErr, protViol;
  int          n_fail = 0;
  int          checks_done = 0;
  logic [15:0] mem [logic [15:0]];
  logic [15:0] d;

  always #2 clk = ~clk;

  dbf_array_access #(.PROG_CYC(16'd20)) dut (
    .clk(clk), .resetn(resetn), .rdReq(rdReq), .rdWordSel(rdWordSel), .rdAddr(rdAddr),
    .pageWindowSelect(pageSel), .rdData(rdData), .rdValid(rdValid), .rdBusy(rdBusy),
    .registerBankChoice(bankSel), .arrWr(arrWr), .arrAddr(arrAddr), .arrData(arrData),
    .cmdWr(cmdWr), .cmdCode(cmdCode), .cmdLaunch(cmdLaunch), .errClr(errClr),
    .ccIntEn(ccIntEn), .cbeIntEn(cbeIntEn), .irqCmdDone(irqCmdDone),
    .irqBufEmpty(irqBufEmpty), .optReady(optReady), .bufEmpty(bufEmpty), .cmdIdle(cmdIdle),
    .cmdDone(cmdDone), .verifyOk(verifyOk), .accErr(accErr), .protViol(protViol),
    .protByte(protByte));

  dbfa_core_model core (
    .clk(clk), .rdReq(rdReq), .rdWordSel(rdWordSel), .rdAddr(rdAddr),
    .pageWindowSelect(pageSel), .rdData(rdData), .rdValid(rdValid), .rdBusy(rdBusy),
    .optReady(optReady), .registerBankChoice(bankSel), .arrWr(arrWr), .arrAddr(arrAddr),
    .arrData(arrData), .cmdWr(cmdWr), .cmdCode(cmdCode), .cmdLaunch(cmdLaunch));

  // Logical address to {block, block relative byte address}
  function automatic logic [16:0] map(input logic [15:0] a, input logic [5:0] pg);
    case (a[15:14])
      2'b00: map = {3'b001, a[13:0]};
      2'b01: map = {3'b010, a[13:0]};
      2'b10: map = {~pg[2], pg[1:0], a[13:0]};
      default: map = {3'b011, a[13:0]};
    endcase
  endfunction

  // Expected byte; unwritten words read erased
  function automatic logic [7:0] ebyte(input logic [15:0] a, input logic [5:0] pg);
    logic [16:0] m;
    logic [15:0] w;
    m = map(a, pg);
    w = mem.exists(m[16:1]) ? mem[m[16:1]] : 16'hffff;
    ebyte = m[0] ? w[7:0] : w[15:8];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read and compare, big endian words, zero padded bytes
  task automatic rd_chk(input logic [15:0] a, input logic [5:0] pg, input logic w);
    logic [15:0] got;
    core.do_read(a, pg, w, got);
    chk(got, w ? {ebyte(a, pg), ebyte(a + 16'h0001, pg)} : {8'h00, ebyte(a, pg)});
  endtask

  // Program only erased words, so new value is the data
  task automatic prog(input logic [15:0] a, input logic [5:0] pg, input logic [15:0] v);
    logic [16:0] m;
    m = map(a, pg);
    core.do_cmd(m[16], a, pg, v, 8'h20);
    mem[m[16:1]] = v;
  endtask

  // Wait for both blocks idle, toggling interrupt enables meanwhile
  task automatic wait_idle;
    int n;
    n = 0;
    // Idle flag trails a launch by two edges, so let those pass first
    repeat (2) @(posedge clk);
    while (cmdIdle !== 2'b11 && n < 40000)
    begin
      ccIntEn <= 1'($urandom);
      cbeIntEn <= 1'($urandom);
      @(posedge clk);
      n++;
    end
    chk(16'(n >= 40000), 16'h0000);
  endtask

  task automatic pulse_clr;
    @(posedge clk);
    errClr <= 1'b1;
    @(posedge clk);
    errClr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, well beyond the longest erase plus verify run
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end

  // Main sequence
  initial
  begin
    void'($urandom(84845));
    repeat (4) @(posedge clk);
    chk({bufEmpty, cmdIdle, protByte[11:0]}, 16'hffff);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(protByte, 16'hffff);
    // Random reads of the erased array through every window but the first, in pages 0x38 to 0x3f
    repeat (24)
      rd_chk(16'($urandom_range(16'hffff, 16'h4000)), 6'h38 + 6'($urandom % 8), 1'($urandom));
    // Both blocks programmed at once, second block 0 command buffered
    d = 16'($urandom);
    prog(16'h8100, 6'h39, d);
    prog(16'hc200, 6'h3f, 16'($urandom));
    prog(16'hc400, 6'h3f, 16'($urandom));
    wait_idle();
    rd_chk(16'hc1ff, 6'h3f, 1'b1);
    rd_chk(16'h8100, 6'h39, 1'b1);
    rd_chk(16'hc201, 6'h3f, 1'b0);
    rd_chk(16'h8400, 6'h3f, 1'b1);
    // Sector erase clears its 512 bytes only
    core.do_cmd(1'b0, 16'hc200, 6'h3f, 16'hffff, 8'h40);
    mem.delete(16'h6100);
    wait_idle();
    rd_chk(16'hc200, 6'h3f, 1'b1);
    rd_chk(16'hc3ff, 6'h3f, 1'b1);
    // Mass erase of block 1 alongside verify of block 0
    core.do_cmd(1'b1, 16'h8000, 6'h39, 16'hffff, 8'h41);
    core.do_cmd(1'b0, 16'hc000, 6'h3f, 16'hffff, 8'h05);
    mem.delete(16'ha080);
    wait_idle();
    chk({15'h0, verifyOk[0]}, 16'h0000);
    rd_chk(16'h8100, 6'h39, 1'b1);
    core.do_cmd(1'b1, 16'h8000, 6'h38, 16'hffff, 8'h05);
    wait_idle();
    chk({15'h0, verifyOk[1]}, 16'h0001);
    // Options word: block 0 fully closed, block 1 lower 512 bytes protected
    prog(16'hff0c, 6'h3f, 16'hf87f);
    wait_idle();
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(protByte, 16'hf87f);
    core.do_cmd(1'b0, 16'hc600, 6'h3f, 16'h0000, 8'h20);
    core.do_cmd(1'b1, 16'h81fe, 6'h38, 16'h0000, 8'h20);
    wait_idle();
    chk({14'h0, protViol}, 16'h0003);
    prog(16'h8200, 6'h38, 16'h5a3c);
    wait_idle();
    rd_chk(16'hc600, 6'h3f, 1'b1);
    rd_chk(16'h81fe, 6'h38, 1'b1);
    rd_chk(16'h8200, 6'h38, 1'b1);
    pulse_clr();
    chk({14'h0, protViol}, 16'h0000);
    // Out of order launch on bank 1, then an illegal code on bank 0
    core.launch_only(1'b1);
    @(posedge clk);
    chk({14'h0, accErr}, 16'h0002);
    core.do_cmd(1'b0, 16'hc800, 6'h3f, 16'h0000, 8'h77);
    @(posedge clk);
    chk({14'h0, accErr}, 16'h0003);
    pulse_clr();
    chk({14'h0, accErr}, 16'h0000);
    wrap_up();
  end
endmodule // testbench
